/* File: design/acr_ctrl.sv */
// How it works
// R01 - The done flag is set by hardware at conversion end and cleared by reading the high result or writing the control register.
// R02 - The done flag in the top bit of the control register is read-only while every other bit reads back what software wrote.
// R03 - The clock-select bit picks a converter clock of the bus clock divided by four when clear and by two when set.
// R04 - Setting the power bit turns the converter on and starts converting, clearing it stops the converter at once.
// R05 - Software keeps the spare bit 4 of the control register at zero.
// R06 - The four channel bits name the analog input as a binary number from input 0 up to input 15.
// R07 - The high result register is read-only and shows result bits 9 to 2.
// R08 - The low result register is read-only with zero in bits 7 to 2 and result bits 1 and 0 below.
// R09 - The control register, high result and low result sit at indices 70h, 71h and 72h.
// R10 - After reset all three converter registers read zero.
// R11 - While powered the selected channel is converted back to back and each result overwrites the last.
// R12 - Changing the channel bits aborts the conversion, clears the done flag and restarts on the new channel.
// R13 - Software polls the done flag, reads low then high before the next conversion ends.
// R14 - Both result registers and the done flag change in the same clock cycle at conversion end.
// R15 - The sequencer settles one result bit per step, most significant first, over ten steps.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_ctrl
  import acr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        comparator_i,
  output var  acr_analog_t analog_o,
  output var  logic        irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  acr_csr_t                  csr;
  acr_csr_t                  next_csr;
  logic [9:0]                result;
  logic [9:0]                next_result;
  logic [`ACR_IRQ_WIDTH-1:0] irq_status;
  logic [`ACR_IRQ_WIDTH-1:0] next_irq_status;
  logic [`ACR_IRQ_WIDTH-1:0] irq_mask;
  logic [`ACR_IRQ_WIDTH-1:0] next_irq_mask;
  logic                      next_irq;
  logic                      next_ack;
  logic [31:0]               next_dat;
  logic                      take;
  logic                      wr_low;
  logic                      restart;
  logic [1:0]                div_cnt;
  logic [1:0]                next_div_cnt;
  logic [1:0]                div_limit;
  logic                      tick;
  logic                      comp_meta;
  logic                      comp_sync;
  logic                      sar_sample;
  logic [9:0]                sar_trial;
  logic                      sar_done;
  logic [9:0]                sar_result;
  acr_analog_t               next_analog;

  // Register index match; the low two address bits select byte lanes only
  function automatic logic acr_hit(input logic [11:0] adr, input logic [9:0] idx);
    acr_hit = (adr[11:2] == idx);
  endfunction : acr_hit

  // Register image read back over the bus, narrow data in the low byte
  function automatic logic [31:0] acr_word(input logic [7:0] val);
    acr_word = {24'h000000, val};
  endfunction : acr_word

  ////////////////////////////////////////////////////////////////////////////
  // Bus qualifiers: a request is taken once, in the cycle before ack rises
  assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_low = take & wb_we_i & wb_sel_i[0];

  // A new conversion starts on power-up or on a channel change while powered
  assign restart = wr_low & acr_hit(wb_adr_i, `ACR_IDX_CSR) // R09
                 & wb_dat_i[`ACR_CSR_PWR_BIT]
                 & (~csr.power_on // R04
                    | (wb_dat_i[`ACR_CSR_CHAN_MSB:0] != csr.input_channel_select)); // R12

  ////////////////////////////////////////////////////////////////////////////
  // Comparator arrives from the analog core asynchronously: two flops first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comparator_i;
      comp_sync <= comp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock as an enable tick; restarting realigns its phase
  always_comb
  begin
    div_limit = csr.clk_fast ? 2'(`ACR_DIV_FAST - 1) : 2'(`ACR_DIV_SLOW - 1); // R03
    tick      = (div_cnt == div_limit);
    if (restart || !csr.power_on || tick)
    begin
      next_div_cnt = 2'h0;
    end
    else
    begin
      next_div_cnt = div_cnt + 2'h1;
    end
  end

  // Divider register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt <= 2'h0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation sequencer
  acr_sar u_sar
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .enable_i  (csr.power_on), // R04
    .restart_i (restart),
    .comp_i    (comp_sync),
    .sample_o  (sar_sample),
    .trial_o   (sar_trial),
    .done_o    (sar_done),
    .result_o  (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control/status and result registers
  always_comb
  begin
    next_csr    = csr;
    next_result = result;
    if (wr_low && acr_hit(wb_adr_i, `ACR_IDX_CSR))
    begin
      // Every bit but the flag takes the written value, spare bit included
      next_csr.clk_fast             = wb_dat_i[`ACR_CSR_CLK_BIT]; // R02
      next_csr.power_on             = wb_dat_i[`ACR_CSR_PWR_BIT]; // R04
      next_csr.rsvd                 = wb_dat_i[`ACR_CSR_RSVD_BIT]; // R02
      next_csr.input_channel_select = wb_dat_i[`ACR_CSR_CHAN_MSB:0]; // R06
      next_csr.eoc                  = 1'b0; // R01
    end
    if (take && !wb_we_i && acr_hit(wb_adr_i, `ACR_IDX_RES_HIGH))
    begin
      next_csr.eoc = 1'b0; // R01
    end
    // Completion beats a clear in the same cycle so no result goes unseen
    if (sar_done)
    begin
      next_csr.eoc = 1'b1; // R14
      next_result  = sar_result; // R11
    end
  end

  // Converter register storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      csr    <= `ACR_CSR_RST; // R10
      result <= `ACR_RESULT_RST; // R10
    end
    else
    begin
      csr    <= next_csr;
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write one to clear, new events win
  always_comb
  begin
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    if (wr_low && acr_hit(wb_adr_i, `ACR_IDX_IRQ_STATUS))
    begin
      next_irq_status = irq_status & ~wb_dat_i[`ACR_IRQ_WIDTH-1:0];
    end
    if (wr_low && acr_hit(wb_adr_i, `ACR_IDX_IRQ_MASK))
    begin
      next_irq_mask = wb_dat_i[`ACR_IRQ_WIDTH-1:0];
    end
    if (sar_done)
    begin
      next_irq_status[`ACR_IRQ_DONE_BIT] = 1'b1;
      // Overrun: the done flag is still set, so no high read and no control write followed the previous result
      if (csr.eoc)
      begin
        next_irq_status[`ACR_IRQ_OVERRUN_BIT] = 1'b1;
      end
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Interrupt registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= `ACR_IRQ_RST;
      irq_mask   <= `ACR_IRQ_RST;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq_o      <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: ack one cycle after the request, unmapped reads zero
  always_comb
  begin
    next_ack = take;
    next_dat = 32'h00000000;
    if (take && !wb_we_i)
    begin
      if (acr_hit(wb_adr_i, `ACR_IDX_CSR))
      begin
        next_dat = acr_word(csr); // R02
      end
      else if (acr_hit(wb_adr_i, `ACR_IDX_RES_HIGH))
      begin
        next_dat = acr_word(result[9:2]); // R07
      end
      else if (acr_hit(wb_adr_i, `ACR_IDX_RES_LOW))
      begin
        next_dat = acr_word({6'h00, result[1:0]}); // R08
      end
      else if (acr_hit(wb_adr_i, `ACR_IDX_IRQ_STATUS))
      begin
        next_dat = acr_word({6'h00, irq_status});
      end
      else if (acr_hit(wb_adr_i, `ACR_IDX_IRQ_MASK))
      begin
        next_dat = acr_word({6'h00, irq_mask});
      end
      else
      begin
        next_dat = 32'h00000000;
      end
    end
  end

  // Bus answer registers; read data is held only for the ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog side: channel and power follow the register, code the sequencer
  always_comb
  begin
    next_analog.converter_power_on   = next_csr.power_on; // R04
    next_analog.input_channel_select = next_csr.input_channel_select; // R06
    next_analog.sample_hold          = sar_sample;
    next_analog.trial_code           = sar_trial;
  end

  // The extra stage delays the trial code one cycle, covered by the settle tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      analog_o <= '0;
    end
    else
    begin
      analog_o <= next_analog;
    end
  end

endmodule : acr_ctrl

`default_nettype wire

/* File: design/acr_map.svh */
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address is four times the index
`define ACR_IDX_CSR        10'h070
`define ACR_IDX_RES_HIGH   10'h071
`define ACR_IDX_RES_LOW    10'h072
`define ACR_IDX_IRQ_STATUS 10'h073
`define ACR_IDX_IRQ_MASK   10'h074

////////////////////////////////////////////////////////////////////////////////
// Field positions in the control/status register
`define ACR_CSR_EOC_BIT    7
`define ACR_CSR_CLK_BIT    6
`define ACR_CSR_PWR_BIT    5
`define ACR_CSR_RSVD_BIT   4
`define ACR_CSR_CHAN_MSB   3

// Interrupt status and mask layout
`define ACR_IRQ_DONE_BIT    0
`define ACR_IRQ_OVERRUN_BIT 1
`define ACR_IRQ_WIDTH       2

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ACR_CSR_RST        8'h00
`define ACR_RESULT_RST     10'h000
`define ACR_IRQ_RST        2'h0

////////////////////////////////////////////////////////////////////////////////
// Converter clock division and conversion length
`define ACR_DIV_SLOW       4
`define ACR_DIV_FAST       2
`define ACR_RESULT_BITS    10

`endif

/* File: design/acr_pkg.sv */
package acr_pkg;

  // Control/status register image
  typedef struct packed {
    logic       eoc;
    logic       clk_fast;
    logic       power_on;
    logic       rsvd;
    logic [3:0] input_channel_select;
  } acr_csr_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ACR_IDLE,
    ACR_SAMPLE,
    ACR_SETTLE,
    ACR_DECIDE
  } acr_sar_state_t;

  // Lines towards the analog multiplexer and core
  typedef struct packed {
    logic       converter_power_on;
    logic       sample_hold;
    logic [3:0] input_channel_select;
    logic [9:0] trial_code;
  } acr_analog_t;

endpackage : acr_pkg

/* File: design/acr_sar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_sar
  import acr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       enable_i,
  input  wire logic       restart_i,
  input  wire logic       comp_i,
  output var  logic       sample_o,
  output var  logic [9:0] trial_o,
  output var  logic       done_o,
  output var  logic [9:0] result_o
);

  acr_sar_state_t state;
  acr_sar_state_t next_state;
  logic [3:0]     bit_idx;
  logic [3:0]     next_bit_idx;
  logic [9:0]     next_trial;
  logic           next_sample;
  logic           next_done;
  logic [9:0]     next_result;
  logic [9:0]     kept;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: a sample tick, then per bit a settle tick and a decide tick,
  // so the comparator has two synchroniser cycles even at the fast clock
  always_comb
  begin
    next_state   = state;
    next_bit_idx = bit_idx;
    next_trial   = trial_o;
    next_sample  = sample_o;
    next_done    = 1'b0;
    next_result  = result_o;
    kept         = trial_o;
    // A power-on restart arrives before the enable register has caught up,
    // so the restart must win or the converter would never start
    if (restart_i)
    begin
      next_state  = ACR_SAMPLE; // R12
      next_trial  = 10'h000;
      next_sample = 1'b1;
    end
    else if (!enable_i)
    begin
      next_state  = ACR_IDLE; // R04
      next_trial  = 10'h000;
      next_sample = 1'b0;
    end
    else if (tick_i)
    begin
      unique case (state)
        ACR_IDLE:
        begin
          next_state = ACR_IDLE;
        end
        ACR_SAMPLE:
        begin
          next_state   = ACR_SETTLE;
          next_sample  = 1'b0;
          next_bit_idx = 4'(`ACR_RESULT_BITS - 1);
          next_trial   = 10'h200; // R15
        end
        ACR_SETTLE:
        begin
          next_state = ACR_DECIDE;
        end
        ACR_DECIDE:
        begin
          // Drop the trial bit when the input lies below the trial level
          if (!comp_i)
          begin
            kept[bit_idx] = 1'b0; // R15
          end
          if (bit_idx == 4'h0)
          begin
            next_done   = 1'b1; // R14
            next_result = kept;
            next_trial  = 10'h000;
            next_sample = 1'b1;
            next_state  = ACR_SAMPLE; // R11
          end
          else
          begin
            next_bit_idx        = bit_idx - 4'h1;
            next_trial          = kept;
            next_trial[bit_idx - 4'h1] = 1'b1; // R15
            next_state          = ACR_SETTLE;
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state    <= ACR_IDLE;
      bit_idx  <= 4'h0;
      trial_o  <= 10'h000;
      sample_o <= 1'b0;
      done_o   <= 1'b0;
      result_o <= `ACR_RESULT_RST;
    end
    else
    begin
      state    <= next_state;
      bit_idx  <= next_bit_idx;
      trial_o  <= next_trial;
      sample_o <= next_sample;
      done_o   <= next_done;
      result_o <= next_result;
    end
  end

endmodule : acr_sar

`default_nettype wire

/* File: verif/acr_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_assertions
  import acr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        comparator_i,
  input wire acr_analog_t analog_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////
  // Bus steps: a fresh request, a control write, a low result read
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_csr_wr;
    s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == `ACR_IDX_CSR;
  endsequence
  sequence s_rd_low;
    s_req ##0 !wb_we_i && wb_adr_i[11:2] == `ACR_IDX_RES_LOW ##1 wb_ack_o;
  endsequence

  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_dat_top;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_top: assert property (p_dat_top) else $error("upper data set");
  // First edge out of reset sees ack, analog lines and interrupt quiet
  property p_rst;
    $fell(rst_i) |-> !wb_ack_o && analog_o == 16'h0000 && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  property p_pwr;
    s_csr_wr |=> analog_o.converter_power_on == $past(wb_dat_i[5]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power line wrong");
  property p_chan;
    s_csr_wr |=> analog_o.input_channel_select == $past(wb_dat_i[3:0]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel lines wrong");
  property p_low;
    s_rd_low |-> wb_dat_o[7:2] == 6'h00;
  endproperty
  a_low: assert property (p_low) else $error("low result upper bits set");
  // The first trial after sampling holds only the top bit
  property p_msb_first;
    $fell(analog_o.sample_hold) && analog_o.converter_power_on
      |-> analog_o.trial_code == 10'h200;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not top bit");

endmodule : acr_assertions
`default_nettype wire

/* File: verif/acr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module acr_core_model
  import acr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire acr_analog_t  analog_i,
  input  wire logic [159:0] levels_i,
  output var  logic         comparator_o
);
  logic [9:0] level;
  logic       cmp_q = 1'b0;

  ////////////////////////////////////////
  // Multiplexer: the channel index is a plain binary input number
  assign level = levels_i[analog_i.input_channel_select * 10 +: 10];

  // Comparator answers at once like the analog part; the design's own
  // synchroniser supplies the delay. Unpowered it toggles so that a stale
  // decision can never pass for a real one
  always_ff @(posedge clk_i)
  begin
    cmp_q <= ~cmp_q;
  end
  assign comparator_o = analog_i.converter_power_on
                      ? (level >= analog_i.trial_code) : cmp_q;

endmodule : acr_core_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"
`define ACR_CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module tb
  import acr_pkg::*;
;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} acr_exp_t;
  localparam logic [11:0] a_csr = {`ACR_IDX_CSR, 2'b00};
  localparam logic [11:0] a_hi  = {`ACR_IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] a_lo  = {`ACR_IDX_RES_LOW, 2'b00};
  localparam logic [11:0] a_ist = {`ACR_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] a_imk = {`ACR_IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] ra [6] = '{a_csr, a_hi, a_lo, a_ist, a_imk, 12'h1D4};
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc   = 1'b0;
  logic         stb   = 1'b0;
  logic         we    = 1'b0;
  logic [11:0]  adr   = 12'h000;
  logic [3:0]   sel   = 4'hF;
  logic [31:0]  wdat  = 32'h00000000;
  logic [31:0]  dout;
  logic         ack;
  logic         cmp;
  logic         irq;
  acr_analog_t  ana;
  logic [159:0] lvl   = 160'h0;
  logic [31:0]  seed  = 32'h00000021;
  acr_exp_t     q[$];
  acr_exp_t     me;
  int           mismatches = 0;
  int           total_checks = 0;
  int           cyc_cnt = 0;

  acr_ctrl acr_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .comparator_i(cmp), .analog_o(ana), .irq_o(irq));
  acr_core_model acr_core_model_inst (.clk_i(clk_i), .analog_i(ana), .levels_i(lvl),
    .comparator_o(cmp));

  ////////////////////////////////////////
  // Clock, and a cycle count that also cuts a hang short
  initial
    forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  // Each read answer is judged against the oldest note
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      me = q.pop_front();
      if (me.m != 32'h00000000)
        `ACR_CHK(dout & me.m, me.e & me.m)
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    bus(a, 1'b0, 8'h00);
  endtask : rd

  // Bounded wait for the interrupt line, counted from t0
  task automatic wait_irq(input int t0, output int t);
    while (irq !== 1'b1 && cyc_cnt - t0 < 400)
      @(posedge clk_i);
    t = cyc_cnt - t0;
  endtask : wait_irq

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////
  initial
  begin : main
    int t0;
    int t;
    int d;
    logic [7:0] c;
    logic [9:0] v;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Seeded levels, with full scale and zero at the two end channels
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      lvl[i*10 +: 10] <= seed[9:0];
    end
    lvl[9:0] <= 10'h3FF;
    lvl[159:150] <= 10'h000;
    @(posedge clk_i);
    foreach (ra[i]) rd(ra[i], 32'h00000000, 32'hFFFFFFFF);
    // Flag bit ignored on write; a write without byte enable is dropped
    wr(a_csr, 8'hCF);
    sel <= 4'h0;
    wr(a_csr, 8'h00);
    sel <= 4'hF;
    rd(a_csr, 32'h0000004F, 32'hFFFFFFFF);
    wr(a_hi, 8'hFF);
    wr(a_lo, 8'hFF);
    rd(a_hi, 32'h00000000, 32'hFFFFFFFF);
    rd(a_lo, 32'h00000000, 32'hFFFFFFFF);
    wr(a_imk, 8'h01);
    // Every channel; each write after the first lands mid-conversion and must restart it
    for (int i = 0; i < 16; i++)
    begin
      c = {2'b00, 1'b1, 1'b0, 4'(i)} | (i[0] ? 8'h40 : 8'h00);
      d = i[0] ? `ACR_DIV_FAST : `ACR_DIV_SLOW;
      v = lvl[i*10 +: 10];
      wr(a_csr, c);
      t0 = cyc_cnt;
      wr(a_ist, 8'h03);
      wait_irq(t0, t);
      `ACR_CHK(t >= 21 * d - 3 && t <= 21 * d + 1, 1'b1)
      rd(a_lo, {30'h0, v[1:0]}, 32'hFFFFFFFF);
      rd(a_hi, {24'h0, v[9:2]}, 32'hFFFFFFFF);
      rd(a_csr, {24'h0, c}, 32'hFFFFFFFF);
    end
    // Masked events stay silent while conversions keep running
    wr(a_imk, 8'h00);
    repeat (60) @(posedge clk_i);
    `ACR_CHK(irq, 1'b0)
    rd(a_ist, 32'h00000001, 32'h00000001);
    rd(a_csr, 32'h00000080, 32'h00000080);
    wr(a_imk, 8'h01);
    t0 = cyc_cnt;
    wr(a_ist, 8'h03);
    wait_irq(t0, t);
    `ACR_CHK(irq, 1'b1)
    // Power off just after a completion, so no late result can slip in
    wr(a_csr, 8'h4F);
    rd(a_csr, 32'h0000004F, 32'hFFFFFFFF);
    wr(a_ist, 8'h03);
    repeat (100) @(posedge clk_i);
    `ACR_CHK(irq, 1'b0)
    rd(a_ist, 32'h00000000, 32'h00000003);
    final_report();
  end

endmodule : tb

bind acr_ctrl acr_assertions acr_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .comparator_i(comparator_i), .analog_o(analog_o), .irq_o(irq_o));
`default_nettype wire
